/* File: core/bsw_cfg.svh */
`ifndef BSW_CFG_SVH
`define BSW_CFG_SVH
// Status word bit positions
`define BSW_BIT_FAULT     15
`define BSW_BIT_TIMEOUT   14
`define BSW_BIT_END       13
`define BSW_BIT_SRQ       12
`define BSW_BIT_DONE      8
`define BSW_BIT_LOCKOUT   7
`define BSW_BIT_FAR       6
`define BSW_BIT_CTRL      5
`define BSW_BIT_ATN       4
`define BSW_BIT_TALK      3
`define BSW_BIT_LISTEN    2
`define BSW_BIT_TRIG      1
`define BSW_BIT_CLEAR     0
// Bus error codes
`define BSW_NO_BUS_ERROR_CODE     4'h0
`define BSW_NOT_CONTROLLER_ERROR  4'h1
`define BSW_NO_LISTENER_ERROR     4'h2
`define BSW_UNADDRESSED_ERROR     4'h3
`define BSW_BAD_ARGUMENT_ERROR    4'h4
`define BSW_NO_SYSTEM_CTRL_ERROR  4'h5
`define BSW_IO_ABORT_ERROR        4'h6
`define BSW_CAPABILITY_OFF_ERROR  4'hB
// Multiline command bytes
`define BSW_CMD_GTL 7'h01
`define BSW_CMD_SDC 7'h04
`define BSW_CMD_GET 7'h08
`define BSW_CMD_TCT 7'h09
`define BSW_CMD_LLO 7'h11
`define BSW_CMD_DCL 7'h14
`define BSW_CMD_UNL 7'h3F
`define BSW_CMD_UNT 7'h5F
// Address groups in bits 6:5
`define BSW_GRP_LISTEN 2'h1
`define BSW_GRP_TALK   2'h2
`define BSW_GRP_SEC    2'h3
// Synchronised pin positions
`define BSW_PIN_ATN 0
`define BSW_PIN_SRQ 1
`define BSW_PIN_REN 2
`define BSW_PIN_IFC 3
// Reset values
`define BSW_SYSCTL_RST 1'b1
`define BSW_PINS_RST   4'hF
`endif

/* File: core/bsw_pkg.sv */
`default_nettype none
package bsw_pkg;
    typedef enum logic [3:0] {
        BSW_CALL_OTHER, BSW_CALL_ONL, BSW_CALL_LOC, BSW_CALL_SIC,
        BSW_CALL_SRE, BSW_CALL_RSC, BSW_CALL_WAIT, BSW_CALL_RD,
        BSW_CALL_WRT, BSW_CALL_CMD, BSW_CALL_GTS, BSW_CALL_STAT
    } bsw_call_kind_t;

    typedef struct packed {
        bsw_call_kind_t kind;
        logic           timed_out;
        logic           aborted;
        logic           no_listener;
        logic           bad_arg;
        logic           cap_off;
        logic           needs_cic;
        logic           wait_timeout_flag_mask;
        logic           shadow_req;
        logic           rsc_on;
        logic           end_seen;
    } bsw_call_t;

    typedef struct packed {
        logic       own;
        logic [7:0] data;
    } bsw_cmd_t;

    typedef struct packed {
        logic [15:0] status;
        logic [3:0]  bus_err;
        logic [3:0]  serial_err;
        logic [15:0] count;
    } bsw_report_t;
endpackage
`default_nettype wire

/* File: core/bsw_status_word.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bsw_cfg.svh"

module bsw_status_word
    import bsw_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Call interface from the parser
    input  wire logic                 call_start,
    input  wire logic                 call_done,
    input  wire bsw_pkg::bsw_call_t   call,
    input  wire logic [3:0]           serial_err,
    input  wire logic [15:0]          xfer_count,
    input  wire logic                 cont_report_en,
    // Bus lines, active low pins
    input  wire logic                 atn_n,
    input  wire logic                 srq_n,
    input  wire logic                 ren_n,
    input  wire logic                 ifc_n,
    // Bus engine events
    input  wire logic                 ifc_own,
    input  wire logic                 cmd_valid,
    input  wire bsw_pkg::bsw_cmd_t    cmd,
    input  wire logic                 shadow_end,
    input  wire logic [4:0]           my_addr,
    input  wire logic                 sec_en,
    input  wire logic [4:0]           my_sec,
    // Status outputs
    output logic [15:0]               call_status_word,
    output logic [3:0]                bus_error_code,
    output logic                      sys_ctrl,
    output logic                      report_valid,
    output bsw_pkg::bsw_report_t      report
);
    import bsw_pkg::*;

    logic [3:0]  sync1_reg;
    logic [3:0]  sync2_reg;
    logic        atn, srq, ren, ifc, ifc_other;
    logic        fault_flag_reg, timeout_flag_reg, end_detected_flag_reg;
    logic        lockout_flag_reg, far_control_flag_reg;
    logic        controller_in_charge_flag_reg;
    logic        talker_addressed_flag_reg, listener_addressed_flag_reg;
    logic        trigger_seen_flag_reg, clear_seen_flag_reg;
    logic        shadow_reg, pend_talk_reg, pend_lsn_reg, report_pend_reg;
    logic [3:0]  err_code_next;
    logic [15:0] status_next;
    logic        is_io, call_ok, is_onl;
    logic        own_lsn, own_talk, own_sec, other_talk;
    logic        talk_hit, lsn_hit, tct_in, tct_out;
    logic [6:0]  cb;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; bus lines are asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_reg <= `BSW_PINS_RST;
            sync2_reg <= `BSW_PINS_RST;
        end
        else
        begin
            sync1_reg <= {ifc_n, ren_n, srq_n, atn_n};
            sync2_reg <= sync1_reg;
        end
    end

    assign atn       = ~sync2_reg[`BSW_PIN_ATN];
    assign srq       = ~sync2_reg[`BSW_PIN_SRQ];
    assign ren       = ~sync2_reg[`BSW_PIN_REN];
    assign ifc       = ~sync2_reg[`BSW_PIN_IFC];
    // Our own IFC must not take control away from us
    assign ifc_other = ifc & ~ifc_own;

    ////////////////////////////////////////////////////////////////////////////////
    // Command byte decode; bit 7 is ignored as on the bus
    assign cb         = cmd.data[6:0];
    assign own_lsn    = cmd_valid && cb[6:5] == `BSW_GRP_LISTEN && cb[4:0] == my_addr;
    assign own_talk   = cmd_valid && cb[6:5] == `BSW_GRP_TALK && cb[4:0] == my_addr;
    assign own_sec    = cmd_valid && cb[6:5] == `BSW_GRP_SEC && cb[4:0] == my_sec;
    assign other_talk = cmd_valid && cb[6:5] == `BSW_GRP_TALK && !own_talk
                        && cb != `BSW_CMD_UNT;
    assign talk_hit   = (own_talk && !sec_en) || (pend_talk_reg && own_sec);
    assign lsn_hit    = (own_lsn && !sec_en) || (pend_lsn_reg && own_sec);
    assign tct_in     = cmd_valid && !cmd.own && cb == `BSW_CMD_TCT
                        && talker_addressed_flag_reg;
    assign tct_out    = cmd_valid && cmd.own && cb == `BSW_CMD_TCT
                        && controller_in_charge_flag_reg;

    // Secondary address must follow its primary directly
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pend_talk_reg <= 1'b0;
            pend_lsn_reg  <= 1'b0;
        end
        else if (cmd_valid)
        begin
            pend_talk_reg <= own_talk && sec_en;
            pend_lsn_reg  <= own_lsn && sec_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Error code of the finishing call, first match wins
    always_comb
    begin
        is_io = call.kind inside {BSW_CALL_RD, BSW_CALL_WRT, BSW_CALL_CMD};
        err_code_next = `BSW_NO_BUS_ERROR_CODE;
        if (call.bad_arg)
            err_code_next = `BSW_BAD_ARGUMENT_ERROR;
        else if (call.cap_off)
            err_code_next = `BSW_CAPABILITY_OFF_ERROR;
        else if ((call.kind == BSW_CALL_SIC || call.kind == BSW_CALL_SRE) && !sys_ctrl)
            err_code_next = `BSW_NO_SYSTEM_CTRL_ERROR;
        else if (call.needs_cic && !controller_in_charge_flag_reg)
            err_code_next = `BSW_NOT_CONTROLLER_ERROR;
        else if ((call.kind == BSW_CALL_RD || call.kind == BSW_CALL_WRT)
                 && !controller_in_charge_flag_reg && !talker_addressed_flag_reg
                 && !listener_addressed_flag_reg)
            err_code_next = `BSW_UNADDRESSED_ERROR;
        else if (call.kind == BSW_CALL_GTS && call.shadow_req && !atn)
            err_code_next = `BSW_UNADDRESSED_ERROR;
        else if (call.no_listener)
            err_code_next = `BSW_NO_LISTENER_ERROR;
        else if (call.aborted)
            err_code_next = `BSW_IO_ABORT_ERROR;
    end

    // A call with any bus error is skipped, so it has no side effects except the END flag of a read
    assign call_ok = call_done && err_code_next == `BSW_NO_BUS_ERROR_CODE;
    assign is_onl  = call_ok && call.kind == BSW_CALL_ONL;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-call results: code, fault and timeout
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bus_error_code   <= `BSW_NO_BUS_ERROR_CODE;
            fault_flag_reg   <= 1'b0;
            timeout_flag_reg <= 1'b0;
        end
        else if (call_done)
        begin
            bus_error_code   <= err_code_next;
            fault_flag_reg   <= err_code_next != `BSW_NO_BUS_ERROR_CODE
                                || serial_err != 4'h0;
            timeout_flag_reg <= call.timed_out
                                && ((call.kind == BSW_CALL_WAIT && call.wait_timeout_flag_mask) || is_io);
        end
    end

    // System controller role, held from power-on
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sys_ctrl <= `BSW_SYSCTL_RST;
        else if (call_ok && call.kind == BSW_CALL_RSC)
            sys_ctrl <= call.rsc_on;
    end

    // Shadow handshake mode after a standby call
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            shadow_reg <= 1'b0;
        else if (call_ok && call.kind == BSW_CALL_GTS)
            shadow_reg <= call.shadow_req;
        else if (is_onl || ifc)
            shadow_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event flags cleared by the next call; a set in the same cycle wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            end_detected_flag_reg <= 1'b0;
            trigger_seen_flag_reg <= 1'b0;
            clear_seen_flag_reg   <= 1'b0;
        end
        else
        begin
            if ((call_done && call.kind == BSW_CALL_RD && call.end_seen)
                || (shadow_reg && shadow_end))
                end_detected_flag_reg <= 1'b1;
            else if (call_start)
                end_detected_flag_reg <= 1'b0;
            if (cmd_valid && !cmd.own && cb == `BSW_CMD_GET && listener_addressed_flag_reg)
                trigger_seen_flag_reg <= 1'b1;
            else if (call_start)
                trigger_seen_flag_reg <= 1'b0;
            if (cmd_valid && !cmd.own && (cb == `BSW_CMD_DCL
                || (cb == `BSW_CMD_SDC && listener_addressed_flag_reg)))
                clear_seen_flag_reg <= 1'b1;
            else if (call_start)
                clear_seen_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Remote and lockout state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lockout_flag_reg <= 1'b0;
        else if (!ren || is_onl)
            lockout_flag_reg <= 1'b0;
        else if (cmd_valid && cb == `BSW_CMD_LLO)
            lockout_flag_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            far_control_flag_reg <= 1'b0;
        else if (!ren || is_onl
                 || (cmd_valid && cb == `BSW_CMD_GTL && listener_addressed_flag_reg)
                 || (call_ok && call.kind == BSW_CALL_LOC && !lockout_flag_reg))
            far_control_flag_reg <= 1'b0;
        else if (lsn_hit)
            far_control_flag_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Controller role
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            controller_in_charge_flag_reg <= 1'b0;
        else if (ifc_other || tct_out || is_onl)
            controller_in_charge_flag_reg <= 1'b0;
        else if ((call_ok && call.kind == BSW_CALL_SIC && sys_ctrl) || tct_in)
            controller_in_charge_flag_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Talker and listener addressing
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            talker_addressed_flag_reg <= 1'b0;
        else if (talk_hit)
            talker_addressed_flag_reg <= 1'b1;
        else if ((cmd_valid && cb == `BSW_CMD_UNT) || other_talk || own_lsn || ifc || is_onl)
            talker_addressed_flag_reg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            listener_addressed_flag_reg <= 1'b0;
        else if (lsn_hit || (call_ok && call.kind == BSW_CALL_GTS && call.shadow_req))
            listener_addressed_flag_reg <= 1'b1;
        else if ((cmd_valid && cb == `BSW_CMD_UNL) || own_talk || ifc || is_onl
                 || (call_ok && call.kind == BSW_CALL_GTS))
            listener_addressed_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status word assembly; weights add as a two's complement word
    always_comb
    begin
        status_next = 16'h0000;
        status_next[`BSW_BIT_FAULT]   = fault_flag_reg;
        status_next[`BSW_BIT_TIMEOUT] = timeout_flag_reg;
        status_next[`BSW_BIT_END]     = end_detected_flag_reg;
        status_next[`BSW_BIT_SRQ]     = srq;
        status_next[`BSW_BIT_DONE]    = 1'b1;
        status_next[`BSW_BIT_LOCKOUT] = lockout_flag_reg;
        status_next[`BSW_BIT_FAR]     = far_control_flag_reg;
        status_next[`BSW_BIT_CTRL]    = controller_in_charge_flag_reg;
        status_next[`BSW_BIT_ATN]     = atn;
        status_next[`BSW_BIT_TALK]    = talker_addressed_flag_reg;
        status_next[`BSW_BIT_LISTEN]  = listener_addressed_flag_reg;
        status_next[`BSW_BIT_TRIG]    = trigger_seen_flag_reg;
        status_next[`BSW_BIT_CLEAR]   = clear_seen_flag_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            call_status_word <= 16'h0100;
        else
            call_status_word <= status_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Report one cycle after the call's effects have settled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            report_pend_reg <= 1'b0;
            report_valid    <= 1'b0;
            report          <= '0;
        end
        else
        begin
            report_pend_reg <= call_done && (cont_report_en || call.kind == BSW_CALL_STAT);
            report_valid    <= report_pend_reg;
            if (report_pend_reg)
                report <= '{status: status_next, bus_err: bus_error_code,
                            serial_err: serial_err, count: xfer_count};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_done_bit;
        @(posedge clk) disable iff (!rst_n) call_status_word[`BSW_BIT_DONE];
    endproperty
    a_done_bit: assert property (p_done_bit) else $error("done bit low");

    property p_srq_follow;
        @(posedge clk) disable iff (!rst_n) (!srq_n)[*4] |-> call_status_word[`BSW_BIT_SRQ];
    endproperty
    a_srq_follow: assert property (p_srq_follow) else $error("srq not followed");

    property p_atn_mirror;
        @(posedge clk) disable iff (!rst_n) (atn_n)[*4] |-> !call_status_word[`BSW_BIT_ATN];
    endproperty
    a_atn_mirror: assert property (p_atn_mirror) else $error("atn not mirrored");

    property p_bad_arg;
        @(posedge clk) disable iff (!rst_n)
            call_done && call.bad_arg |=> bus_error_code == `BSW_BAD_ARGUMENT_ERROR
            ##1 call_status_word[`BSW_BIT_FAULT];
    endproperty
    a_bad_arg: assert property (p_bad_arg) else $error("bad argument not flagged");

    property p_no_sysctl;
        @(posedge clk) disable iff (!rst_n)
            call_done && call.kind == BSW_CALL_SIC && !call.bad_arg && !call.cap_off
            && !sys_ctrl |=> bus_error_code == `BSW_NO_SYSTEM_CTRL_ERROR;
    endproperty
    a_no_sysctl: assert property (p_no_sysctl) else $error("missing code 5");

    property p_ren_release;
        @(posedge clk) disable iff (!rst_n)
            (ren_n)[*3] |=> !lockout_flag_reg && !far_control_flag_reg;
    endproperty
    a_ren_release: assert property (p_ren_release) else $error("remote kept");

    property p_end_clear;
        @(posedge clk) disable iff (!rst_n)
            call_start && !call_done && !shadow_reg |=> !end_detected_flag_reg;
    endproperty
    a_end_clear: assert property (p_end_clear) else $error("end flag kept");

    property p_report;
        @(posedge clk) disable iff (!rst_n)
            call_done && cont_report_en |-> ##2 report_valid && report.status[`BSW_BIT_DONE];
    endproperty
    a_report: assert property (p_report) else $error("report missing");

    property p_sic_ctrl;
        @(posedge clk) disable iff (!rst_n)
            call_ok && call.kind == BSW_CALL_SIC && !ifc_other && !tct_out
            |-> ##2 call_status_word[`BSW_BIT_CTRL];
    endproperty
    a_sic_ctrl: assert property (p_sic_ctrl) else $error("control not taken");
endmodule // bsw_status_word

`default_nettype wire

/* File: verif/bsw_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Other bus parties: drive the control lines and report command bytes
module bsw_bus_model
    import bsw_pkg::*;
(
    // Clock
    input  wire logic          clk,
    // Bus lines, active low
    output logic               atn_n,
    output logic               srq_n,
    output logic               ren_n,
    output logic               ifc_n,
    // Command byte events
    output logic               cmd_valid,
    output bsw_pkg::bsw_cmd_t  cmd
);
    import bsw_pkg::*;

    // Idle bus: all lines released, no byte in flight
    initial
    begin
        {ifc_n, ren_n, srq_n, atn_n} = 4'hF;
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // Lines change only at the falling edge, away from sampling
    task automatic pins(input logic [3:0] p);
        @(negedge clk);
        {ifc_n, ren_n, srq_n, atn_n} = p;
    endtask

    // One byte for one cycle; data inverted afterwards so stale bytes never match
    task automatic send(input logic own, input logic [7:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd       = {own, d};
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd       = {~own, ~d};
    endtask
endmodule // bsw_bus_model
`default_nettype wire

/* File: verif/bsw_status_word_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module bsw_status_word_bench;
    import bsw_pkg::*;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              call_start = 1'b0;
    logic              call_done = 1'b0;
    bsw_call_t         call = '0;
    logic              atn_n, srq_n, ren_n, ifc_n, cmd_valid, sys_ctrl, report_valid;
    bsw_cmd_t          cmd;
    logic [15:0]       call_status_word;
    logic [3:0]        bus_error_code;
    bsw_report_t       report;
    int                error_cnt = 0;
    int                total_checks = 0;
    int                cyc = 0;
    logic [15:0]       w;
    logic [3:0]        serial_err = 4'h0;
    logic              cont_report_en = 1'b1, shadow_end = 1'b0, sec_en = 1'b0, end_bit = 1'b0;

    always #5 clk = ~clk;

    bsw_bus_model u_bsw_bus_model (.clk(clk), .atn_n(atn_n), .srq_n(srq_n),
        .ren_n(ren_n), .ifc_n(ifc_n), .cmd_valid(cmd_valid), .cmd(cmd));

    bsw_status_word u_bsw_status_word (.clk(clk), .rst_n(rst_n),
        .call_start(call_start), .call_done(call_done), .call(call),
        .serial_err(serial_err), .xfer_count(16'h0007), .cont_report_en(cont_report_en),
        .atn_n(atn_n), .srq_n(srq_n), .ren_n(ren_n), .ifc_n(ifc_n),
        .ifc_own(1'b0), .cmd_valid(cmd_valid), .cmd(cmd), .shadow_end(shadow_end),
        .my_addr(5'h05), .sec_en(sec_en), .my_sec(5'h00),
        .call_status_word(call_status_word), .bus_error_code(bus_error_code),
        .sys_ctrl(sys_ctrl), .report_valid(report_valid), .report(report));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Start pulse, then the finishing pulse; word and report settle two edges on
    task automatic do_call(input bsw_call_kind_t k, input logic [8:0] f,
                           input logic [3:0] ec, input logic [15:0] ew);
        @(negedge clk);
        call_start = 1'b1;
        @(negedge clk);
        call_start = 1'b0;
        call_done  = 1'b1;
        call       = {k, f, end_bit};
        @(negedge clk);
        call_done = 1'b0;
        chk("code", {12'h0, bus_error_code}, {12'h0, ec});
        @(negedge clk);
        chk("word", call_status_word, ew);
        chk("rvalid", {15'h0, report_valid}, 16'h0001);
        chk("rword", report.status, ew);
        chk("rcode", {12'h0, report.bus_err}, {12'h0, ec});
    endtask

    // Hang guard, far above the roughly 110 cycles the sequence needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command bytes with the word they leave, then calls with code and word
    logic [7:0]        cb [6] = '{8'h25, 8'h11, 8'h08, 8'h14, 8'h45, 8'h5F};
    logic [15:0]       cw [6] = '{16'h0154, 16'h01D4, 16'h01D6, 16'h01D7, 16'h01DB, 16'h01D3};
    logic [7:0]        sb [3] = '{8'h3F, 8'h25, 8'h60};
    logic [15:0]       sw [3] = '{16'h8110, 16'h8110, 16'h8114};
    bsw_call_kind_t    ck [10] = '{BSW_CALL_OTHER, BSW_CALL_RD, BSW_CALL_OTHER,
        BSW_CALL_OTHER, BSW_CALL_SIC, BSW_CALL_WAIT, BSW_CALL_WRT, BSW_CALL_WRT,
        BSW_CALL_RSC, BSW_CALL_SIC};
    logic [8:0]        cf [10] = '{9'h020, 9'h000, 9'h008, 9'h010, 9'h000, 9'h104,
        9'h040, 9'h180, 9'h000, 9'h000};
    logic [3:0]        ce [10] = '{4'h4, 4'h3, 4'h1, 4'hB, 4'h0, 4'h0, 4'h2, 4'h6, 4'h0, 4'h5};
    logic [15:0]       cx [10] = '{16'h81D0, 16'h81D0, 16'h81D0, 16'h81D0, 16'h01F0,
        16'h41F0, 16'h81F0, 16'hC1F0, 16'h01F0, 16'h81F0};

    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("reset word", call_status_word, 16'h0100);
        chk("sysctl", {15'h0, sys_ctrl}, 16'h0001);
        // Service request line, three edges through the synchroniser
        u_bsw_bus_model.pins(4'hD);
        repeat (4) @(negedge clk);
        chk("srq", call_status_word, 16'h1100);
        u_bsw_bus_model.pins(4'hA);
        repeat (4) @(negedge clk);
        chk("atn", call_status_word, 16'h0110);
        for (int i = 0; i < 6; i++)
        begin
            u_bsw_bus_model.send(1'b0, cb[i]);
            @(negedge clk);
            chk("cmd word", call_status_word, cw[i]);
        end
        for (int i = 0; i < 10; i++)
            do_call(ck[i], cf[i], ce[i], cx[i]);
        chk("sysctl off", {15'h0, sys_ctrl}, 16'h0000);
        // Online call drops lockout, far control and controller role
        do_call(BSW_CALL_ONL, 9'h000, 4'h0, 16'h0110);
        // Far control again, then REN release clears it
        u_bsw_bus_model.send(1'b0, 8'h25);
        u_bsw_bus_model.pins(4'hE);
        repeat (4) @(negedge clk);
        w = 16'h0114;
        chk("ren off", call_status_word, w);
        // Unlisten, then standby with shadow handshake makes us listener
        u_bsw_bus_model.send(1'b0, 8'h3F);
        @(negedge clk);
        chk("unlisten", call_status_word, 16'h0110);
        do_call(BSW_CALL_GTS, 9'h002, 4'h0, 16'h0114);
        @(negedge clk);
        shadow_end = 1'b1;
        @(negedge clk);
        shadow_end = 1'b0;
        @(negedge clk);
        chk("shadow end", call_status_word, 16'h2114);
        end_bit = 1'b1;
        do_call(BSW_CALL_RD, 9'h000, 4'h0, 16'h2114);
        end_bit = 1'b0;
        // Requested report only; a serial error alone raises the fault flag
        serial_err     = 4'h2;
        cont_report_en = 1'b0;
        do_call(BSW_CALL_STAT, 9'h000, 4'h0, 16'h8114);
        chk("rserial", {12'h0, report.serial_err}, 16'h0002);
        chk("rcount", report.count, 16'h0007);
        // Secondary addressing: listener only once primary and secondary both hit
        sec_en = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            u_bsw_bus_model.send(1'b0, sb[i]);
            @(negedge clk);
            chk("sec word", call_status_word, sw[i]);
        end
        give_verdict();
    end
endmodule // bsw_status_word_bench
`default_nettype wire
